// *** src/tile_control_status_regs.sv ***
`timescale 1ns/10ps
// processor-status register bank: features, boot report, security, rings
module tile_control_status_regs
(
  // clock, resets, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic ce,
  // processor-status access port
  input wire logic ps_req,
  input wire logic ps_we,
  input wire logic [15:0] ps_res,
  input wire logic [31:0] ps_wdata,
  output logic [31:0] ps_rdata,
  output logic ps_ack,
  output logic ps_err,
  // boot straps, sampled once after reset
  input wire logic [7:0] strap_proc_num,
  input wire logic strap_boot_ovr,
  input wire logic strap_core1_off,
  input wire logic strap_no_otp_poll,
  input wire logic strap_boot_ram,
  input wire logic strap_boot_jtag,
  input wire logic [1:0] strap_pll_mode,
  // security word from the OTP reader
  input wire logic [31:0] otp_sec_word,
  input wire logic otp_sec_valid,
  // thread state and oscillator ticks
  input wire logic threads_paused,
  input wire logic [3:0] ro_tick,
  // RGMII, clock divider and USB controls
  output logic rgmii_tx_clk,
  output logic [7:0] rgmii_tx_delay,
  output logic rgmii_port_en,
  output logic clk_div_active,
  output logic usb_utmi_sel,
  output logic ulpi_hw_en,
  // security controls
  output logic gdbg_disable,
  output logic jtag_tap_disable,
  output logic otp_lock_all,
  output logic [3:0] otp_sector_lock,
  output logic otp_redundancy_en,
  output logic otp_boot_force,
  output logic jtag_cfg_block
);
  typedef struct packed {
    logic [31:0] fc;
    logic [31:0] boot;
    logic [31:0] sec;
    logic core_en;
    logic periph_en;
    logic strap_done;
    logic div_act;
    logic [31:0] rdata;
    logic ack;
    logic err;
  } bank_s;
  bank_s st_r;
  bank_s st_nxt;

  tile_aux_if aux ();

  // transmit clock helper
  rgmii_txclk_gen u_txgen
  (
    .mclk (mclk),
    .rst_n (rst_n),
    .ce (ce),
    .aux (aux.txgen)
  );

  // ring counters, on the power-on reset only
  ring_osc_counters u_osc
  (
    .mclk (mclk),
    .por_n (por_n),
    .ce (ce),
    .ro_tick (ro_tick),
    .aux (aux.osc)
  );

  // next state: straps, software access, OTP load, divider gating
  always_comb
  begin
    logic [7:0] num;
    logic type_ok;
    logic [7:0] ro_off;
    logic ro_reg;
    num = ps_res[tcs_pkg::PS_NUM_SHIFT +: tcs_pkg::PS_NUM_W];
    type_ok = 1'b0;
    ro_off = 8'h00;
    ro_reg = 1'b0;
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    // only processor-status resource ids are accepted
    type_ok = ps_res[tcs_pkg::PS_NUM_SHIFT-1:0] == tcs_pkg::PS_RES_TYPE;
    ro_off = num - tcs_pkg::REG_RO_VAL0;
    ro_reg = num >= tcs_pkg::REG_RO_VAL0 && ro_off < 8'(tcs_pkg::RO_NUM);

    // straps caught on the first enabled edge after release
    if (!st_r.strap_done)
    begin
      st_nxt.strap_done = 1'b1;
      st_nxt.boot = '0;
      st_nxt.boot[tcs_pkg::BS_PROC_LSB +: tcs_pkg::BS_PROC_W] =
        strap_proc_num;
      // override, core off, no-poll, RAM and JTAG boot flags
      st_nxt.boot[tcs_pkg::BS_OVR] = strap_boot_ovr;
      st_nxt.boot[tcs_pkg::BS_CORE1_OFF] = strap_core1_off;
      st_nxt.boot[tcs_pkg::BS_NO_POLL] = strap_no_otp_poll;
      st_nxt.boot[tcs_pkg::BS_RAM] = strap_boot_ram;
      st_nxt.boot[tcs_pkg::BS_JTAG] = strap_boot_jtag;
      st_nxt.boot[tcs_pkg::BS_PLL_LSB +: tcs_pkg::BS_PLL_W] =
        strap_pll_mode;
    end

    // software access, answered one edge later
    if (ps_req)
    begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = '0;
      if (!type_ok)
        st_nxt.err = 1'b1;
      else if (ps_we)
      begin
        unique case (num)
          tcs_pkg::REG_FEATURE:
            // delay, divider, enables and USB mode written together
            st_nxt.fc = ps_wdata & tcs_pkg::FC_MASK;
          tcs_pkg::REG_SEC:
          begin
            // a locked word ignores software writes; only reset or an OTP load changes it
            if (!st_r.sec[tcs_pkg::SC_WR_LOCK])
              st_nxt.sec = ps_wdata & tcs_pkg::SC_MASK;
          end
          tcs_pkg::REG_RO_CTL:
          begin
            // start and stop the two ring groups
            st_nxt.core_en = ps_wdata[tcs_pkg::RO_CORE_EN];
            st_nxt.periph_en = ps_wdata[tcs_pkg::RO_PERIPH_EN];
          end
          default:
            // boot report, counts and unmapped numbers refuse writes
            st_nxt.err = 1'b1;
        endcase
      end
      else
      begin
        unique case (num)
          tcs_pkg::REG_FEATURE:
            st_nxt.rdata = st_r.fc;
          tcs_pkg::REG_BOOT:
            // boot report is only ever read
            st_nxt.rdata = st_r.boot;
          tcs_pkg::REG_SEC:
            st_nxt.rdata = st_r.sec;
          tcs_pkg::REG_RO_CTL:
          begin
            st_nxt.rdata[tcs_pkg::RO_CORE_EN] = st_r.core_en;
            st_nxt.rdata[tcs_pkg::RO_PERIPH_EN] = st_r.periph_en;
          end
          default:
          begin
            // counts sit in the four numbers after control
            if (ro_reg)
              st_nxt.rdata[tcs_pkg::RO_CNT_W-1:0] =
                aux.ro_count[ro_off[1:0]];
            else
              st_nxt.err = 1'b1;
          end
        endcase
      end
    end

    // the OTP copy wins over a software write in the same cycle
    if (otp_sec_valid)
      st_nxt.sec = otp_sec_word & tcs_pkg::SC_MASK;

    // dynamic mode waits for all threads to pause
    st_nxt.div_act = st_r.fc[tcs_pkg::FC_DIV_EN] &&
      (!st_r.fc[tcs_pkg::FC_DYN] || threads_paused);
  end

  // state register; the rings keep their own power-on reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.fc <= tcs_pkg::FC_RESET;
      st_r.sec <= tcs_pkg::SC_RESET;
    end
    else if (ce)
      st_r <= st_nxt;
  end

  // helper settings
  assign aux.tx_div = st_r.fc[tcs_pkg::FC_DIV_LSB +: tcs_pkg::FC_DIV_W];
  assign aux.tx_run = st_r.fc[tcs_pkg::FC_RGMII_EN];
  assign aux.core_en = st_r.core_en;
  assign aux.periph_en = st_r.periph_en;

  // access answer; the ack is masked so a frozen cycle cannot repeat it
  assign ps_rdata = st_r.rdata;
  assign ps_ack = st_r.ack & ce;
  assign ps_err = st_r.err;

  // port enable gates the RGMII pins and clock
  assign rgmii_port_en = st_r.fc[tcs_pkg::FC_RGMII_EN];
  assign rgmii_tx_clk = aux.tx_clk;
  assign rgmii_tx_delay =
    st_r.fc[tcs_pkg::FC_DELAY_LSB +: tcs_pkg::FC_DELAY_W];
  // division request, registered through the pause gate
  assign clk_div_active = st_r.div_act;
  assign usb_utmi_sel = st_r.fc[tcs_pkg::FC_UTMI];
  assign ulpi_hw_en = st_r.fc[tcs_pkg::FC_ULPI_EN];

  assign gdbg_disable = st_r.sec[tcs_pkg::SC_NO_GDBG];
  assign jtag_tap_disable = st_r.sec[tcs_pkg::SC_NO_JTAG_TAP];
  assign otp_lock_all = st_r.sec[tcs_pkg::SC_OTP_LOCK_ALL];
  assign otp_sector_lock =
    st_r.sec[tcs_pkg::SC_OTP_LOCK_LSB +: tcs_pkg::SC_OTP_LOCK_W];
  // OTP redundancy, OTP boot and JTAG config block
  assign otp_redundancy_en = st_r.sec[tcs_pkg::SC_OTP_RED];
  assign otp_boot_force = st_r.sec[tcs_pkg::SC_OTP_BOOT];
  assign jtag_cfg_block = st_r.sec[tcs_pkg::SC_NO_JTAG_CFG];

  property p_fc_write;
    @(posedge mclk) disable iff (!rst_n)
      ce && ps_req && ps_we && ps_res == {tcs_pkg::REG_FEATURE,
      tcs_pkg::PS_RES_TYPE} |=>
      rgmii_tx_delay == $past(ps_wdata[25:18]) &&
      rgmii_port_en == $past(ps_wdata[8]);
  endproperty
  a_fc_write: assert property (p_fc_write)
    else $error("feature write did not reach delay or port enable");

  property p_div_gate;
    @(posedge mclk) disable iff (!rst_n)
      ce && st_r.fc[tcs_pkg::FC_DIV_EN] && st_r.fc[tcs_pkg::FC_DYN] &&
      !threads_paused |=> !clk_div_active;
  endproperty
  a_div_gate: assert property (p_div_gate)
    else $error("dynamic divider engaged while a thread ran");

  property p_div_static;
    @(posedge mclk) disable iff (!rst_n)
      ce && st_r.fc[tcs_pkg::FC_DIV_EN] && !st_r.fc[tcs_pkg::FC_DYN]
      |=> clk_div_active;
  endproperty
  a_div_static: assert property (p_div_static)
    else $error("static divider not applied");

  property p_boot_ro;
    @(posedge mclk) disable iff (!rst_n)
      ce && st_r.strap_done && ps_req && ps_we &&
      ps_res == {tcs_pkg::REG_BOOT, tcs_pkg::PS_RES_TYPE}
      |=> $stable(st_r.boot) && ps_err;
  endproperty
  a_boot_ro: assert property (p_boot_ro)
    else $error("boot report changed on a write");

  property p_sec_lock;
    @(posedge mclk) disable iff (!rst_n)
      ce && st_r.sec[31] && !otp_sec_valid |=> $stable(st_r.sec);
  endproperty
  a_sec_lock: assert property (p_sec_lock)
    else $error("locked security word changed");

  property p_sec_load;
    @(posedge mclk) disable iff (!rst_n)
      ce && otp_sec_valid |=>
      st_r.sec == ($past(otp_sec_word) & 32'h8000_5fb1);
  endproperty
  a_sec_load: assert property (p_sec_load)
    else $error("security word not copied from OTP");

  property p_ro_read;
    @(posedge mclk) disable iff (!rst_n)
      ce && ps_req && !ps_we &&
      ps_res == {tcs_pkg::REG_RO_VAL0, tcs_pkg::PS_RES_TYPE} |=>
      ps_rdata == {16'h0000, $past(aux.ro_count[0])} && !ps_err;
  endproperty
  a_ro_read: assert property (p_ro_read)
    else $error("count read returned wrong value");

  property p_bad_type;
    @(posedge mclk) disable iff (!rst_n)
      ce && ps_req && ps_res[7:0] != 8'h0b |=> st_r.ack && ps_err;
  endproperty
  a_bad_type: assert property (p_bad_type)
    else $error("foreign resource id not refused");

  property p_ro_ctl;
    @(posedge mclk) disable iff (!rst_n)
      ce && ps_req && ps_we &&
      ps_res == {tcs_pkg::REG_RO_CTL, tcs_pkg::PS_RES_TYPE} |=>
      aux.core_en == $past(ps_wdata[1]) &&
      aux.periph_en == $past(ps_wdata[0]);
  endproperty
  a_ro_ctl: assert property (p_ro_ctl)
    else $error("ring enables not written");

  property p_strap_cap;
    @(posedge mclk) disable iff (!rst_n)
      ce && !st_r.strap_done |=>
      st_r.boot[23:16] == $past(strap_proc_num) &&
      st_r.boot[1:0] == $past(strap_pll_mode);
  endproperty
  a_strap_cap: assert property (p_strap_cap)
    else $error("straps not captured into boot report");
endmodule

// *** src/tcs_pkg.sv ***
// register numbers, field layout, reset values and sizes of the status bank
package tcs_pkg;
  // processor-status resource encoding
  localparam int PS_NUM_SHIFT = 8;
  localparam int PS_NUM_W = 8;
  localparam logic [7:0] PS_RES_TYPE = 8'h0b;
  // register numbers
  localparam logic [7:0] REG_FEATURE = 8'h02;
  localparam logic [7:0] REG_BOOT = 8'h03;
  localparam logic [7:0] REG_SEC = 8'h05;
  localparam logic [7:0] REG_RO_CTL = 8'h06;
  localparam logic [7:0] REG_RO_VAL0 = 8'h07;
  localparam int RO_NUM = 4;
  localparam int RO_CNT_W = 16;
  // feature control fields
  localparam int FC_DELAY_LSB = 18;
  localparam int FC_DELAY_W = 8;
  localparam int FC_DIV_LSB = 9;
  localparam int FC_DIV_W = 9;
  localparam int FC_RGMII_EN = 8;
  localparam int FC_DYN = 5;
  localparam int FC_DIV_EN = 4;
  localparam int FC_UTMI = 2;
  localparam int FC_ULPI_EN = 1;
  localparam logic [31:0] FC_MASK = 32'h03ff_ff36;
  localparam logic [31:0] FC_RESET = 32'h0000_0000;
  // boot report fields
  localparam int BS_PROC_LSB = 16;
  localparam int BS_PROC_W = 8;
  localparam int BS_OVR = 8;
  localparam int BS_CORE1_OFF = 5;
  localparam int BS_NO_POLL = 4;
  localparam int BS_RAM = 3;
  localparam int BS_JTAG = 2;
  localparam int BS_PLL_LSB = 0;
  localparam int BS_PLL_W = 2;
  // security settings fields
  localparam int SC_WR_LOCK = 31;
  localparam int SC_NO_GDBG = 14;
  localparam int SC_OTP_LOCK_ALL = 12;
  localparam int SC_OTP_LOCK_LSB = 8;
  localparam int SC_OTP_LOCK_W = 4;
  localparam int SC_OTP_RED = 7;
  localparam int SC_OTP_BOOT = 5;
  localparam int SC_NO_JTAG_CFG = 4;
  localparam int SC_NO_JTAG_TAP = 0;
  localparam logic [31:0] SC_MASK = 32'h8000_5fb1;
  localparam logic [31:0] SC_RESET = 32'h0000_0000;
  // ring oscillator control fields
  localparam int RO_PERIPH_EN = 0;
  localparam int RO_CORE_EN = 1;
endpackage

// *** src/tile_aux_if.sv ***
`timescale 1ns/10ps
// carries divider settings and oscillator counts between bank and helpers
interface tile_aux_if;
  logic [tcs_pkg::FC_DIV_W-1:0] tx_div;
  logic tx_run;
  logic tx_clk;
  logic core_en;
  logic periph_en;
  logic [tcs_pkg::RO_NUM-1:0][tcs_pkg::RO_CNT_W-1:0] ro_count;
  modport bank (output tx_div, output tx_run, output core_en,
                output periph_en, input tx_clk, input ro_count);
  modport txgen (input tx_div, input tx_run, output tx_clk);
  modport osc (input core_en, input periph_en, output ro_count);
endinterface

// *** src/rgmii_txclk_gen.sv ***
`timescale 1ns/10ps
// transmit clock generator: a wrapping counter with two edge matches
module rgmii_txclk_gen
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // settings in, clock out
  tile_aux_if.txgen aux
);
  typedef struct packed {
    logic [tcs_pkg::FC_DIV_W-1:0] cnt;
    logic clk;
  } txgen_s;
  txgen_s st_r;
  txgen_s st_nxt;

  // next count and clock level
  always_comb
  begin
    st_nxt = st_r;
    if (!aux.tx_run)
    begin
      st_nxt.cnt = '0;
      st_nxt.clk = 1'b0;
    end
    else
    begin
      // wrap at field, ratio is field plus one
      if (st_r.cnt >= aux.tx_div)
        st_nxt.cnt = '0;
      else
        st_nxt.cnt = st_r.cnt + 1'b1;
      if (st_r.cnt == aux.tx_div)
        st_nxt.clk = 1'b1;
      else if (st_r.cnt == (aux.tx_div >> 1))
        st_nxt.clk = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign aux.tx_clk = st_r.clk;

  property p_tx_rise;
    @(posedge mclk) disable iff (!rst_n)
      ce && aux.tx_run && st_r.cnt == aux.tx_div |=> aux.tx_clk;
  endproperty
  a_tx_rise: assert property (p_tx_rise)
    else $error("tx clock did not rise on divider match");

  property p_tx_fall;
    @(posedge mclk) disable iff (!rst_n)
      ce && aux.tx_run && st_r.cnt == (aux.tx_div >> 1) &&
      st_r.cnt != aux.tx_div |=> !aux.tx_clk;
  endproperty
  a_tx_fall: assert property (p_tx_fall)
    else $error("tx clock did not fall on half match");
endmodule

// *** src/ring_osc_counters.sv ***
`timescale 1ns/10ps
// four oscillator counters, cleared only at power-on
module ring_osc_counters
(
  // clock, power-on reset, enable
  input wire logic mclk,
  input wire logic por_n,
  input wire logic ce,
  // oscillator ticks, one per ring
  input wire logic [tcs_pkg::RO_NUM-1:0] ro_tick,
  // enables in, counts out
  tile_aux_if.osc aux
);
  typedef struct packed {
    logic [tcs_pkg::RO_NUM-1:0][tcs_pkg::RO_CNT_W-1:0] cnt;
  } osc_s;
  osc_s st_r;
  osc_s st_nxt;
  logic [tcs_pkg::RO_CNT_W-1:0] cnt_nxt [tcs_pkg::RO_NUM];

  // first half on the core enable, second half on the peripheral enable
  genvar gi;
  generate
    for (gi = 0; gi < tcs_pkg::RO_NUM; gi++)
    begin : g_osc
      logic run;
      assign run = (gi < tcs_pkg::RO_NUM / 2) ? aux.core_en : aux.periph_en;
      assign cnt_nxt[gi] = (run && ro_tick[gi]) ?
        st_r.cnt[gi] + 1'b1 : st_r.cnt[gi];
    end
  endgenerate

  // gather the per-ring next values
  always_comb
  begin
    st_nxt = st_r;
    for (int i = 0; i < tcs_pkg::RO_NUM; i++)
      st_nxt.cnt[i] = cnt_nxt[i];
  end

  // system reset leaves the counts alone
  always_ff @(posedge mclk or negedge por_n)
  begin
    if (!por_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign aux.ro_count = st_r.cnt;

  property p_osc_hold;
    @(posedge mclk) disable iff (!por_n)
      !aux.core_en |=> $stable(st_r.cnt[0]);
  endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("stopped counter moved");

  property p_osc_step;
    @(posedge mclk) disable iff (!por_n)
      ce && aux.periph_en && ro_tick[2] |=>
      st_r.cnt[2] == 16'($past(st_r.cnt[2]) + 16'h0001);
  endproperty
  a_osc_step: assert property (p_osc_step)
    else $error("running counter missed a tick");
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
// self-checking bench for the processor-status register bank
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("BAD %0t got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top;
  // clock, resets, enable
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic ce = 1'b1;
  // access port
  logic ps_req = 1'b0;
  logic ps_we = 1'b0;
  logic [15:0] ps_res = 16'h0000;
  logic [31:0] ps_wdata = 32'h0000_0000;
  logic [31:0] ps_rdata;
  logic ps_ack;
  logic ps_err;
  // straps, otp word, thread state, ticks
  logic [7:0] strap_num = 8'h5a;
  logic [1:0] strap_pll = 2'h2;
  logic [31:0] otp_sec_word = 32'h0000_0000;
  logic otp_sec_valid = 1'b0;
  logic threads_paused = 1'b0;
  logic [3:0] ro_tick = 4'h0;
  // outputs under test
  logic rgmii_tx_clk, rgmii_port_en, clk_div_active, usb_utmi_sel;
  logic ulpi_hw_en, gdbg_disable, jtag_tap_disable, otp_lock_all;
  logic otp_redundancy_en, otp_boot_force, jtag_cfg_block;
  logic [7:0] rgmii_tx_delay;
  logic [3:0] otp_sector_lock;
  // bench state
  int err_count = 0;
  int n_compared = 0;
  logic [31:0] rd_q;
  logic er_q;
  logic [8:0] divs [4] = '{9'h000, 9'h004, 9'h007, 9'h1ff};
  logic [15:0] ro_exp [4];
  int hi;

  tile_control_status_regs DUT (.mclk(mclk), .rst_n(rst_n), .por_n(por_n),
    .ce(ce), .ps_req(ps_req), .ps_we(ps_we), .ps_res(ps_res),
    .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_ack(ps_ack),
    .ps_err(ps_err), .strap_proc_num(strap_num), .strap_boot_ovr(1'b1),
    .strap_core1_off(1'b0), .strap_no_otp_poll(1'b1),
    .strap_boot_ram(1'b0), .strap_boot_jtag(1'b1),
    .strap_pll_mode(strap_pll),
    .otp_sec_word(otp_sec_word), .otp_sec_valid(otp_sec_valid),
    .threads_paused(threads_paused), .ro_tick(ro_tick),
    .rgmii_tx_clk(rgmii_tx_clk), .rgmii_tx_delay(rgmii_tx_delay),
    .rgmii_port_en(rgmii_port_en), .clk_div_active(clk_div_active),
    .usb_utmi_sel(usb_utmi_sel), .ulpi_hw_en(ulpi_hw_en),
    .gdbg_disable(gdbg_disable), .jtag_tap_disable(jtag_tap_disable),
    .otp_lock_all(otp_lock_all), .otp_sector_lock(otp_sector_lock),
    .otp_redundancy_en(otp_redundancy_en), .otp_boot_force(otp_boot_force),
    .jtag_cfg_block(jtag_cfg_block));

  // 125 MHz core clock
  initial
  begin
    forever #4 mclk = ~mclk;
  end

  // counts, verdict, end of run
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // wait n edges, then sample off the edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one access; request held until the taking edge, answer bounded
  task automatic ps_acc(input logic we, input logic [7:0] num,
                        input logic [31:0] wd, input logic [7:0] typ);
    int n;
    n = 0;
    @(posedge mclk);
    ps_req <= 1'b1;
    ps_we <= we;
    ps_res <= {num, typ};
    ps_wdata <= wd;
    @(posedge mclk);
    ps_req <= 1'b0;
    #1;
    while (ps_ack !== 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
    if (ps_ack !== 1'b1)
    begin
      err_count++;
      $display("BAD %0t no answer to access", $time);
      complete_run();
    end
    rd_q = ps_rdata;
    er_q = ps_err;
  endtask

  task automatic wr(input logic [7:0] num, input logic [31:0] wd);
    ps_acc(1'b1, num, wd, tcs_pkg::PS_RES_TYPE);
    `CHK(er_q, 1'b0)
  endtask

  task automatic rd_chk(input logic [7:0] num, input logic [31:0] exp);
    ps_acc(1'b0, num, 32'h0000_0000, tcs_pkg::PS_RES_TYPE);
    `CHK(rd_q, exp)
    `CHK(er_q, 1'b0)
  endtask

  // system reset only; power-on reset stays released
  task automatic sys_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    step(3);
  endtask

  // one-cycle load strobe from the otp reader
  task automatic otp_load(input logic [31:0] w);
    @(posedge mclk);
    otp_sec_word <= w;
    otp_sec_valid <= 1'b1;
    @(posedge mclk);
    otp_sec_valid <= 1'b0;
    step(1);
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    step(3);
    // reset values and the read-only boot word
    rd_chk(tcs_pkg::REG_FEATURE, 32'h0000_0000);
    rd_chk(tcs_pkg::REG_RO_CTL, 32'h0000_0000);
    rd_chk(tcs_pkg::REG_BOOT, 32'h005a_0116);
    ps_acc(1'b1, tcs_pkg::REG_BOOT, 32'hffff_ffff, tcs_pkg::PS_RES_TYPE);
    `CHK(er_q, 1'b1)
    rd_chk(tcs_pkg::REG_BOOT, 32'h005a_0116);
    `CHK(rgmii_port_en, 1'b0)
    $display("test reset done");
    // feature word: every writable field, reserved bits masked
    wr(tcs_pkg::REG_FEATURE, 32'hffff_ffff);
    rd_chk(tcs_pkg::REG_FEATURE, tcs_pkg::FC_MASK);
    `CHK(rgmii_tx_delay, 8'hff)
    `CHK({rgmii_port_en, usb_utmi_sel, ulpi_hw_en}, 3'h7)
    wr(tcs_pkg::REG_FEATURE, 32'h0294_0002);
    step(1);
    `CHK(rgmii_tx_delay, 8'ha5)
    `CHK({rgmii_port_en, usb_utmi_sel, ulpi_hw_en}, 3'h1)
    $display("test feature done");
    // divider engage: static always, dynamic only while paused
    wr(tcs_pkg::REG_FEATURE, 32'h0000_0010);
    step(2);
    `CHK(clk_div_active, 1'b1)
    wr(tcs_pkg::REG_FEATURE, 32'h0000_0030);
    step(2);
    `CHK(clk_div_active, 1'b0)
    @(posedge mclk);
    threads_paused <= 1'b1;
    step(2);
    `CHK(clk_div_active, 1'b1)
    wr(tcs_pkg::REG_FEATURE, 32'h0000_0020);
    step(2);
    `CHK(clk_div_active, 1'b0)
    $display("test divider done");
    // transmit clock duty over four whole periods per divider
    foreach (divs[i])
    begin
      wr(tcs_pkg::REG_FEATURE, 32'h0000_0000);
      step(2);
      `CHK(rgmii_tx_clk, 1'b0)
      wr(tcs_pkg::REG_FEATURE, {14'h0000, divs[i], 9'h100});
      step(2 * (int'(divs[i]) + 1) + 2);
      hi = 0;
      repeat (4 * (int'(divs[i]) + 1))
      begin
        step(1);
        if (rgmii_tx_clk === 1'b1)
          hi++;
      end
      `CHK(hi, 4 * (int'(divs[i] >> 1) + 1))
    end
    $display("test tx clock done");
    // security word: otp copy, lock, reload after reset
    otp_load(32'hffff_ffff);
    rd_chk(tcs_pkg::REG_SEC, tcs_pkg::SC_MASK);
    `CHK({gdbg_disable, jtag_tap_disable, otp_lock_all}, 3'h7)
    `CHK({otp_sector_lock, otp_redundancy_en}, 5'h1f)
    `CHK({otp_boot_force, jtag_cfg_block}, 2'h3)
    wr(tcs_pkg::REG_SEC, 32'h0000_0000);
    rd_chk(tcs_pkg::REG_SEC, tcs_pkg::SC_MASK);
    // new strap levels only reach the boot word at the next reset
    @(posedge mclk);
    strap_num <= 8'h3c;
    strap_pll <= 2'h1;
    rd_chk(tcs_pkg::REG_BOOT, 32'h005a_0116);
    sys_reset();
    rd_chk(tcs_pkg::REG_BOOT, 32'h003c_0115);
    rd_chk(tcs_pkg::REG_SEC, 32'h0000_0000);
    wr(tcs_pkg::REG_SEC, 32'h4000_4a14);
    rd_chk(tcs_pkg::REG_SEC, 32'h0000_4a10);
    `CHK({gdbg_disable, jtag_tap_disable, otp_lock_all}, 3'h4)
    `CHK({otp_sector_lock, otp_redundancy_en}, 5'h14)
    `CHK({otp_boot_force, jtag_cfg_block}, 2'h1)
    otp_load(32'h0000_1021);
    rd_chk(tcs_pkg::REG_SEC, 32'h0000_1021);
    $display("test security done");
    // ring counters: core pair then peripheral pair
    wr(tcs_pkg::REG_RO_CTL, 32'h0000_0002);
    rd_chk(tcs_pkg::REG_RO_CTL, 32'h0000_0002);
    @(posedge mclk);
    ro_tick <= 4'hf;
    repeat (5) @(posedge mclk);
    ro_tick <= 4'h0;
    wr(tcs_pkg::REG_RO_CTL, 32'h0000_0001);
    @(posedge mclk);
    ro_tick <= 4'hf;
    repeat (3) @(posedge mclk);
    ro_tick <= 4'h0;
    wr(tcs_pkg::REG_RO_CTL, 32'hffff_fffc);
    // settle time before reading stopped counters
    step(10);
    ro_exp = '{16'h0005, 16'h0005, 16'h0003, 16'h0003};
    for (int i = 0; i < 4; i++)
      rd_chk(tcs_pkg::REG_RO_VAL0 + 8'(i), {16'h0000, ro_exp[i]});
    sys_reset();
    for (int i = 0; i < 4; i++)
      rd_chk(tcs_pkg::REG_RO_VAL0 + 8'(i), {16'h0000, ro_exp[i]});
    $display("test rings done");
    // refused accesses: bad type byte, unmapped, read-only targets
    ps_acc(1'b0, tcs_pkg::REG_FEATURE, 32'h0000_0000, 8'h0c);
    `CHK(er_q, 1'b1)
    ps_acc(1'b0, 8'h04, 32'h0000_0000, tcs_pkg::PS_RES_TYPE);
    `CHK({er_q, rd_q}, 33'h1_0000_0000)
    ps_acc(1'b1, tcs_pkg::REG_RO_VAL0, 32'h0000_ffff,
           tcs_pkg::PS_RES_TYPE);
    `CHK(er_q, 1'b1)
    rd_chk(tcs_pkg::REG_RO_VAL0, 32'h0000_0005);
    $display("test refusals done");
    // frozen enable: ticks seen while ce is low must not count
    wr(tcs_pkg::REG_RO_CTL, 32'h0000_0001);
    @(posedge mclk);
    ce <= 1'b0;
    ro_tick <= 4'hf;
    repeat (4) @(posedge mclk);
    ce <= 1'b1;
    ro_tick <= 4'h0;
    wr(tcs_pkg::REG_RO_CTL, 32'h0000_0000);
    step(10);
    rd_chk(tcs_pkg::REG_RO_VAL0 + 8'h02, 32'h0000_0003);
    $display("test freeze done");
    complete_run();
  end
endmodule
